// ---- verilog/imf_sample_fifo.v ----
// Purpose: accel byte fifo with framed readout and gyro frame fifo
// Assumes: register port driven by the serial interface on sys_clk
// Notes:   irq pins are synchronised; accel samples arrive with valid/ready, gyro with valid only
// Notes on behaviour
// - accel store holds 1024 bytes of frames, one sample per data frame
// - accel capture runs only while enable bit 6 of 0x49 is set
// - bit 0 of 0x48 picks overwrite (0, default) or stop-when-full (1)
// - accel input rate is output rate divided by 2^k, k from 0x45 bits 6:4
// - configured input pins a/b tag header bits 0/1 of data frames
// - data frame is header 100001 plus tags, then six x,y,z bytes
// - after overflow readout starts with skip frame counting lost frames
// - burst emptying fifo gets sensortime frame latched at last byte read
// - config change inserts config frame; bit1 range, bit0 filter/rate
// - dropped sample stores a two-byte drop frame in its slot
// - partly read frame repeats next burst; overreads return 0x8000
// - accel full interrupt when level passes two frames below capacity
// - accel watermark interrupt when level at or above watermark
// - interrupts held off during data reads; clear on status read below
// - writing 0xb0 to 0x7e resets the accel fifo
// - gyro fifo holds 100 frames of three rate words plus interrupt word
// - 0x34 bit 5 enables tag mode, bit 4 picks the tag pin
// - z lsb is tag: high while pin high, one more word after fall
// - gyro read through 0x3f; partly read frame is dropped at burst end
// - 0x0e shows frame count and overrun; overrun clears on config write
// - gyro full after 100 frames in stop mode, 99 in overwrite_mode mode
// - gyro watermark at count reaching 0x3d; writing 0x3d empties fifo
// - overwrite_mode mode discards oldest when full; stop mode ceases storing
`timescale 1ns/100ps
`include "imf_regs.vh"
module imf_sample_fifo #(
  parameter ACC_DEPTH = 1024,
  parameter ACC_AW    = 10,
  parameter GYR_DEPTH = 100
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        reg_gyro_sel,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire        reg_burst_end,
  output reg  [7:0]  reg_rdata,
  input  wire [47:0] accel_sample,
  input  wire        accel_sample_drop,
  input  wire        accel_sample_valid,
  output wire        accel_sample_ready,
  input  wire        accel_range_change,
  input  wire        accel_filter_change,
  input  wire [23:0] sensortime,
  input  wire [47:0] gyro_sample,
  input  wire [15:0] gyro_int_data,
  input  wire        gyro_sample_valid,
  input  wire        accel_irq_pin_a,
  input  wire        accel_irq_pin_b,
  input  wire        gyro_irq_pin_a,
  input  wire        gyro_irq_pin_b,
  output reg         accel_fifo_full_irq,
  output reg         accel_fifo_wm_irq,
  output wire        gyro_fifo_irq
);
  localparam GCW = 7;
  localparam [10:0] ACC_DEPTH_W = ACC_DEPTH;
  localparam [GCW-1:0] GYR_N = GYR_DEPTH;

  // pin synchronisers
  reg  [3:0] pin_s1;
  reg  [3:0] pin_s2;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {gyro_irq_pin_b, gyro_irq_pin_a,
                 accel_irq_pin_b, accel_irq_pin_a};
      pin_s2 <= pin_s1;
    end
  end

  // configuration registers
  reg  [7:0]  acc_downs;
  reg  [7:0]  acc_mode;
  reg  [7:0]  acc_en;
  reg  [12:0] acc_wtm;
  reg  [7:0]  pina_setup;
  reg  [7:0]  pinb_setup;
  reg  [7:0]  gyr_tag;
  reg  [7:0]  gyr_wtm;
  reg  [7:0]  gyr_mode;
  wire acc_wr = reg_wr & ~reg_gyro_sel;
  wire gyr_wr = reg_wr & reg_gyro_sel;
  wire acc_rst = acc_wr & (reg_addr == `IMF_ACC_CMD) &
                 (reg_wdata == `IMF_CMD_FIFO_RST);
  wire acc_data_rd = reg_rd & ~reg_gyro_sel & (reg_addr == `IMF_ACC_DATA);
  wire acc_stat_rd = reg_rd & ~reg_gyro_sel & (reg_addr == `IMF_ACC_STAT);
  wire gyr_data_rd = reg_rd & reg_gyro_sel & (reg_addr == `IMF_GYR_DATA);
  wire gyr_cfg_wr  = gyr_wr & ((reg_addr == `IMF_GYR_WTM) |
                               (reg_addr == `IMF_GYR_MODE));
  wire downs_wr    = acc_wr & (reg_addr == `IMF_ACC_DOWNS);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_downs  <= `IMF_ACC_DS_RST;
      acc_mode   <= `IMF_ACC_MODE_RST;
      acc_en     <= `IMF_ACC_EN_RST;
      acc_wtm    <= `IMF_ACC_WTM_RST;
      pina_setup <= 8'h00;
      pinb_setup <= 8'h00;
      gyr_tag    <= 8'h00;
      gyr_wtm    <= 8'h00;
      gyr_mode   <= 8'h00;
    end else if (reg_wr) begin
      if (reg_gyro_sel) begin
        case (reg_addr)
          `IMF_GYR_TAG:  gyr_tag  <= reg_wdata;
          `IMF_GYR_WTM:  gyr_wtm  <= reg_wdata;
          `IMF_GYR_MODE: gyr_mode <= reg_wdata;
          default: ;
        endcase
      end else begin
        case (reg_addr)
          `IMF_ACC_DOWNS: acc_downs <= reg_wdata;
          `IMF_ACC_WTM0:  acc_wtm[7:0] <= reg_wdata;
          `IMF_ACC_WTM1:  acc_wtm[12:8] <= reg_wdata[4:0];
          `IMF_ACC_MODE:  acc_mode <= reg_wdata;
          `IMF_ACC_EN:    acc_en <= reg_wdata;
          `IMF_ACC_PINA:  pina_setup <= reg_wdata;
          `IMF_ACC_PINB:  pinb_setup <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // decimation and two-entry sample buffer
  reg  [48:0] buf_q0;
  reg  [48:0] buf_q1;
  reg  [1:0]  buf_cnt;
  reg  [6:0]  ds_cnt;
  wire [2:0]  ds_k = acc_downs[`IMF_ACC_DS_LSB+2:`IMF_ACC_DS_LSB];
  wire [6:0]  ds_mask = (7'h01 << ds_k) - 7'h01;
  assign accel_sample_ready = (buf_cnt != 2'd2);
  wire in_push = accel_sample_valid & accel_sample_ready;
  wire in_keep = in_push & acc_en[`IMF_ACC_EN_BIT] &
                 ((ds_cnt & ds_mask) == 7'h00);
  wire buf_valid = (buf_cnt != 2'd0);
  wire buf_pop;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q0  <= 49'h0;
      buf_q1  <= 49'h0;
      buf_cnt <= 2'd0;
      ds_cnt  <= 7'h00;
    end else if (acc_rst) begin
      buf_cnt <= 2'd0;
      ds_cnt  <= 7'h00;
    end else begin
      if (in_push)
        ds_cnt <= ds_cnt + 7'h01;
      if (buf_pop)
        buf_q0 <= buf_q1;
      if (in_keep & buf_pop & (buf_cnt == 2'd1))
        buf_q0 <= {accel_sample_drop, accel_sample};
      else if (in_keep & ~buf_pop & (buf_cnt == 2'd0))
        buf_q0 <= {accel_sample_drop, accel_sample};
      if (in_keep & ((buf_cnt == 2'd1) & ~buf_pop |
                     (buf_cnt == 2'd2) & buf_pop))
        buf_q1 <= {accel_sample_drop, accel_sample};
      buf_cnt <= buf_cnt + {1'b0, in_keep} - {1'b0, buf_pop};
    end
  end

  // accel byte store
  reg  [7:0]  acc_mem [0:ACC_DEPTH-1];
  reg  [ACC_AW-1:0] wp;
  reg  [ACC_AW-1:0] rp;
  reg  [10:0] acc_cnt;
  reg  [55:0] fb;
  reg  [2:0]  wr_left;
  reg  [2:0]  wr_len;
  reg  [1:0]  cfg_pend;
  reg  [7:0]  skip_cnt;
  reg  [2:0]  rd_off;
  reg         skip_pos;
  reg         time_armed;
  reg  [1:0]  time_pos;
  reg  [23:0] time_q;
  reg         ovr_pos;
  reg         acc_rd_active;

  function [2:0] frame_len;
    input [7:0] hdr;
    begin
      frame_len = (hdr[7:2] == `IMF_HDR_DATA) ? 3'd7 : 3'd2;
    end
  endfunction

  wire        wr_idle   = (wr_left == 3'd0);
  wire [10:0] inflight  = wr_idle ? 11'd0 : {8'h00, wr_len - wr_left};
  wire [7:0]  rp_hdr    = acc_mem[rp];
  wire [2:0]  rp_len    = frame_len(rp_hdr);
  wire [10:0] ready_cnt = acc_cnt - inflight;
  wire        stop_mode = acc_mode[`IMF_ACC_STOP_BIT];
  wire [1:0]  tags = {pinb_setup[`IMF_PIN_IN_BIT] &
                      acc_en[`IMF_ACC_RECB_BIT] & pin_s2[1],
                      pina_setup[`IMF_PIN_IN_BIT] &
                      acc_en[`IMF_ACC_RECA_BIT] & pin_s2[0]};
  wire        want_cfg  = wr_idle & (cfg_pend != 2'b00);
  wire        want_smp  = wr_idle & ~want_cfg & buf_valid;
  wire [2:0]  new_len   = (want_smp & ~buf_q0[48]) ? 3'd7 : 3'd2;
  wire        no_room   = (ACC_DEPTH_W - acc_cnt) < {8'h00, new_len};
  wire        want_any  = want_cfg | want_smp;
  wire        drop_old  = want_any & no_room & ~stop_mode & ~acc_data_rd &
                          (ready_cnt != 11'd0) & (rd_off == 3'd0);
  wire        lose_new  = want_any & no_room & stop_mode;
  wire        start_new = want_any & ~no_room;
  assign buf_pop = want_smp & (start_new | lose_new);
  wire        wr_en     = ~wr_idle;

  // reader decisions
  wire        rd_skip   = acc_data_rd & ((skip_cnt != 8'h00) | skip_pos);
  wire        rd_frame  = acc_data_rd & ~rd_skip &
                          ((rd_off != 3'd0) | (ready_cnt != 11'd0));
  wire        rd_commit = rd_frame & (rd_off + 3'd1 == rp_len);
  wire        rd_time   = acc_data_rd & ~rd_skip & ~rd_frame & time_armed;
  wire        rd_ovr    = acc_data_rd & ~rd_skip & ~rd_frame & ~time_armed;
  wire [10:0] sub_len   = rd_commit ? {8'h00, rp_len} :
                          drop_old  ? {8'h00, rp_len} : 11'd0;

  always @(posedge sys_clk) begin
    if (wr_en)
      acc_mem[wp] <= fb[55:48];
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= {ACC_AW{1'b0}};
      rp <= {ACC_AW{1'b0}};
      acc_cnt <= 11'd0;
      fb <= 56'h0;
      wr_left <= 3'd0;
      wr_len <= 3'd0;
      cfg_pend <= 2'b00;
      skip_cnt <= 8'h00;
      rd_off <= 3'd0;
      skip_pos <= 1'b0;
      time_armed <= 1'b0;
      time_pos <= 2'd0;
      time_q <= 24'h0;
      ovr_pos <= 1'b0;
      acc_rd_active <= 1'b0;
    end else if (acc_rst) begin
      wp <= {ACC_AW{1'b0}};
      rp <= {ACC_AW{1'b0}};
      acc_cnt <= 11'd0;
      wr_left <= 3'd0;
      wr_len <= 3'd0;
      skip_cnt <= 8'h00;
      rd_off <= 3'd0;
      skip_pos <= 1'b0;
      time_armed <= 1'b0;
      time_pos <= 2'd0;
      ovr_pos <= 1'b0;
    end else begin
      acc_cnt <= acc_cnt + {10'h000, wr_en} - sub_len;
      cfg_pend <= (start_new & want_cfg ? 2'b00 : cfg_pend) |
                  {accel_range_change, accel_filter_change | downs_wr};
      if (wr_en) begin
        wp <= wp + 1'b1;
        fb <= {fb[47:0], 8'h00};
        wr_left <= wr_left - 3'd1;
      end else if (start_new) begin
        wr_left <= new_len;
        wr_len <= new_len;
        if (want_cfg)
          fb <= {`IMF_HDR_CFG, 6'h00, cfg_pend, 40'h0};
        else if (buf_q0[48])
          fb <= {`IMF_HDR_DROP, 8'h00, 40'h0};
        else
          fb <= {`IMF_HDR_DATA, tags, buf_q0[47:0]};
      end
      if ((drop_old | lose_new) & (skip_cnt != 8'hff))
        skip_cnt <= skip_cnt + 8'h01;
      if (drop_old)
        rp <= rp + {{(ACC_AW-3){1'b0}}, rp_len};
      if (rd_skip) begin
        skip_pos <= ~skip_pos;
        if (skip_pos)
          skip_cnt <= {7'h00, lose_new};
      end
      if (rd_frame) begin
        rd_off <= rd_commit ? 3'd0 : rd_off + 3'd1;
        if (rd_commit) begin
          rp <= rp + {{(ACC_AW-3){1'b0}}, rp_len};
          if (ready_cnt == {8'h00, rp_len}) begin
            time_armed <= 1'b1;
            time_q <= sensortime;
          end
        end
      end
      if (rd_time) begin
        time_pos <= time_pos + 2'd1;
        if (time_pos == 2'd3)
          time_armed <= 1'b0;
      end
      if (rd_ovr)
        ovr_pos <= ~ovr_pos;
      if (acc_data_rd)
        acc_rd_active <= 1'b1;
      if (reg_burst_end) begin
        rd_off <= 3'd0;
        acc_rd_active <= 1'b0;
        time_armed <= 1'b0;
        time_pos <= 2'd0;
        ovr_pos <= 1'b0;
        skip_pos <= 1'b0;
      end
    end
  end

  // accel interrupts
  wire acc_full_cond = acc_cnt > (ACC_DEPTH_W - `IMF_FULL_MARGIN);
  wire acc_wm_cond   = acc_cnt >= {1'b0, acc_wtm[9:0]} &
                       (acc_wtm[12:10] == 3'd0);
  wire irq_hold      = acc_rd_active | acc_data_rd;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accel_fifo_full_irq <= 1'b0;
      accel_fifo_wm_irq   <= 1'b0;
    end else begin
      if (acc_full_cond & ~irq_hold)
        accel_fifo_full_irq <= 1'b1;
      else if (acc_stat_rd & ~acc_full_cond)
        accel_fifo_full_irq <= 1'b0;
      if (acc_wm_cond & ~irq_hold)
        accel_fifo_wm_irq <= 1'b1;
      else if (acc_stat_rd & ~acc_wm_cond)
        accel_fifo_wm_irq <= 1'b0;
    end
  end

  // gyro frame store
  reg  [63:0] gyr_mem [0:GYR_DEPTH-1];
  reg  [GCW-1:0] gw;
  reg  [GCW-1:0] gr;
  reg  [GCW-1:0] gcnt;
  reg  [2:0]  gbyte;
  reg         govr;
  reg         tag_prev;
  wire g_on     = gyr_mode[`IMF_GYR_STOP_BIT] | gyr_mode[`IMF_GYR_STRM_BIT];
  wire g_overwrite_mode = gyr_mode[`IMF_GYR_STRM_BIT];
  wire g_pin    = gyr_tag[`IMF_TAG_SEL_BIT] ? pin_s2[3] : pin_s2[2];
  wire g_tag    = g_pin | tag_prev;
  wire g_pop    = (gyr_data_rd & (gcnt != 0) & (gbyte == 3'd7)) |
                  (reg_burst_end & (gbyte != 3'd0));
  wire g_full   = (gcnt == GYR_N) & ~g_pop;
  wire g_in     = gyro_sample_valid & g_on & ~gyr_cfg_wr;
  wire g_store  = g_in & (~g_full | g_overwrite_mode);
  wire g_over   = g_in & g_full & g_overwrite_mode;
  wire [GCW-1:0] g_wrap = GYR_N - 1'b1;
  wire [63:0] g_word = {gyro_int_data, gyro_sample[47:33],
                        gyr_tag[`IMF_TAG_EN_BIT] ? g_tag : gyro_sample[32],
                        gyro_sample[31:0]};

  always @(posedge sys_clk) begin
    if (g_store)
      gyr_mem[gw] <= g_word;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gw <= {GCW{1'b0}};
      gr <= {GCW{1'b0}};
      gcnt <= {GCW{1'b0}};
      gbyte <= 3'd0;
      govr <= 1'b0;
      tag_prev <= 1'b0;
    end else if (gyr_cfg_wr) begin
      gw <= {GCW{1'b0}};
      gr <= {GCW{1'b0}};
      gcnt <= {GCW{1'b0}};
      gbyte <= 3'd0;
      govr <= 1'b0;
    end else begin
      if (g_store) begin
        gw <= (gw == g_wrap) ? {GCW{1'b0}} : gw + 1'b1;
        tag_prev <= g_pin;
      end
      if (g_pop | g_over)
        gr <= (gr == g_wrap) ? {GCW{1'b0}} : gr + 1'b1;
      gcnt <= gcnt + {{(GCW-1){1'b0}}, g_store & ~g_over} -
              {{(GCW-1){1'b0}}, g_pop};
      if (g_in & g_full)
        govr <= 1'b1;
      if (reg_burst_end)
        gbyte <= 3'd0;
      else if (gyr_data_rd & (gcnt != 0))
        gbyte <= gbyte + 3'd1;
    end
  end

  wire g_full_int = g_overwrite_mode ? (gcnt >= GYR_N - 1'b1)
                             : (gcnt == GYR_N);
  wire g_wm_int   = (gyr_wtm[6:0] != 7'h00) & (gcnt >= gyr_wtm[6:0]);
  assign gyro_fifo_irq = g_on & (g_full_int | g_wm_int);

  // register read data
  wire [63:0] g_rd_word = gyr_mem[gr];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_gyro_sel) begin
        case (reg_addr)
          `IMF_GYR_STAT: reg_rdata <= {3'b000, gyro_fifo_irq, 4'h0};
          `IMF_GYR_FILL: reg_rdata <= {govr, gcnt};
          `IMF_GYR_TAG:  reg_rdata <= gyr_tag;
          `IMF_GYR_WTM:  reg_rdata <= gyr_wtm;
          `IMF_GYR_MODE: reg_rdata <= gyr_mode;
          `IMF_GYR_DATA:
            if (gcnt != 0)
              reg_rdata <= g_rd_word[gbyte*8 +: 8];
          default: ;
        endcase
      end else begin
        case (reg_addr)
          `IMF_ACC_LEN0:  reg_rdata <= acc_cnt[7:0];
          `IMF_ACC_LEN1:  reg_rdata <= {5'h00, acc_cnt[10:8]};
          `IMF_ACC_STAT:  reg_rdata <= {6'h00, accel_fifo_full_irq,
                                        accel_fifo_wm_irq};
          `IMF_ACC_DOWNS: reg_rdata <= acc_downs;
          `IMF_ACC_WTM0:  reg_rdata <= acc_wtm[7:0];
          `IMF_ACC_WTM1:  reg_rdata <= {3'b000, acc_wtm[12:8]};
          `IMF_ACC_MODE:  reg_rdata <= acc_mode;
          `IMF_ACC_EN:    reg_rdata <= acc_en;
          `IMF_ACC_PINA:  reg_rdata <= pina_setup;
          `IMF_ACC_PINB:  reg_rdata <= pinb_setup;
          `IMF_ACC_DATA: begin
            if (rd_skip)
              reg_rdata <= skip_pos ? skip_cnt : `IMF_HDR_SKIP;
            else if (rd_frame)
              reg_rdata <= acc_mem[rp + {{(ACC_AW-3){1'b0}}, rd_off}];
            else if (rd_time)
              case (time_pos)
                2'd0:    reg_rdata <= `IMF_HDR_TIME;
                2'd1:    reg_rdata <= time_q[7:0];
                2'd2:    reg_rdata <= time_q[15:8];
                default: reg_rdata <= time_q[23:16];
              endcase
            else
              reg_rdata <= ovr_pos ? `IMF_OVR_LO : `IMF_OVR_HI;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // imf_sample_fifo

// ---- verilog/imf_regs.vh ----
// Purpose: register offsets, field positions, frame codes and reset values
// Assumes: byte-wide registers, accel and gyro maps selected by a map input
// Notes:   included by the sample fifo top module
`ifndef IMF_REGS_VH
`define IMF_REGS_VH
// accel map
`define IMF_ACC_LEN0      8'h24
`define IMF_ACC_LEN1      8'h25
`define IMF_ACC_DATA      8'h26
`define IMF_ACC_STAT      8'h1e
`define IMF_ACC_DOWNS     8'h45
`define IMF_ACC_WTM0      8'h46
`define IMF_ACC_WTM1      8'h47
`define IMF_ACC_MODE      8'h48
`define IMF_ACC_EN        8'h49
`define IMF_ACC_PINA      8'h53
`define IMF_ACC_PINB      8'h54
`define IMF_ACC_CMD       8'h7e
// gyro map
`define IMF_GYR_STAT      8'h0a
`define IMF_GYR_FILL      8'h0e
`define IMF_GYR_TAG       8'h34
`define IMF_GYR_WTM       8'h3d
`define IMF_GYR_MODE      8'h3e
`define IMF_GYR_DATA      8'h3f
// field positions
`define IMF_ACC_EN_BIT    6
`define IMF_ACC_RECA_BIT  2
`define IMF_ACC_RECB_BIT  3
`define IMF_ACC_STOP_BIT  0
`define IMF_ACC_DS_LSB    4
`define IMF_PIN_IN_BIT    4
`define IMF_TAG_EN_BIT    5
`define IMF_TAG_SEL_BIT   4
`define IMF_GYR_STOP_BIT  6
`define IMF_GYR_STRM_BIT  7
`define IMF_GYR_INT_BIT   4
// frame codes and commands
`define IMF_HDR_DATA      6'h21
`define IMF_HDR_SKIP      8'h40
`define IMF_HDR_TIME      8'h44
`define IMF_HDR_CFG       8'h48
`define IMF_HDR_DROP      8'h50
`define IMF_CMD_FIFO_RST  8'hb0
`define IMF_OVR_HI        8'h80
`define IMF_OVR_LO        8'h00
`define IMF_FULL_MARGIN   11'd14
// reset values
`define IMF_ACC_EN_RST    8'h10
`define IMF_ACC_MODE_RST  8'h02
`define IMF_ACC_DS_RST    8'h80
`define IMF_ACC_WTM_RST   13'h0200
`endif

// ---- bench/imf_fifo_props.sv ----
// Purpose: concurrent checks on the sample fifo ports
// Assumes: register strobes last one sys_clk cycle
// Notes:   bound to every imf_sample_fifo instance
`timescale 1ns/100ps
`include "imf_regs.vh"
module imf_fifo_props (
  input wire       sys_clk,
  input wire       rst_n,
  input wire       reg_gyro_sel,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       accel_sample_valid,
  input wire       accel_sample_ready,
  input wire       gyro_sample_valid,
  input wire       accel_fifo_full_irq,
  input wire       accel_fifo_wm_irq,
  input wire       gyro_fifo_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire acc = !reg_gyro_sel;
  wire nv  = !gyro_sample_valid;
  wire drd = reg_rd && acc && reg_addr == `IMF_ACC_DATA;
  wire srd = reg_rd && acc && reg_addr == `IMF_ACC_STAT;
  wire gwr = reg_wr && reg_gyro_sel;
  wire cmd = reg_wr && acc && reg_addr == `IMF_ACC_CMD;
  wire rsw = cmd && reg_wdata == `IMF_CMD_FIFO_RST;
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_WM_QUIET: assert property (drd |=> !$rose(accel_fifo_wm_irq))
    else $error("watermark irq rose during data read");
  AST_FULL_QUIET: assert property (drd |=> !$rose(accel_fifo_full_irq))
    else $error("full irq rose during data read");
  AST_IRQ_CLEAR: assert property ($fell(accel_fifo_wm_irq) ||
    $fell(accel_fifo_full_irq) |-> $past(srd) || $past(srd, 2))
    else $error("accel irq cleared without status read");
  AST_READY_BACK: assert property (!accel_sample_ready |->
    ##[1:20] accel_sample_ready)
    else $error("sample buffer stayed full");
  AST_GYR_WM_EMPTY: assert property (gwr && reg_addr == `IMF_GYR_WTM && nv
    ##1 nv |-> !gyro_fifo_irq)
    else $error("gyro irq after watermark write");
  AST_GYR_CFG_CLR: assert property (gwr && reg_addr == `IMF_GYR_MODE && nv
    ##1 nv ##1 reg_rd && reg_gyro_sel && reg_addr == `IMF_GYR_FILL && nv
    |=> reg_rdata == 8'h00)
    else $error("gyro fill not cleared by config write");
  AST_RST_EMPTY: assert property (rsw && !accel_sample_valid
    ##2 reg_rd && acc && reg_addr == `IMF_ACC_LEN0 |=> reg_rdata == 8'h00)
    else $error("accel length not cleared by fifo reset");
  cover property (drd);
  cover property ($rose(accel_fifo_full_irq));
  cover property ($rose(gyro_fifo_irq));
endmodule // imf_fifo_props
bind imf_sample_fifo imf_fifo_props chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_gyro_sel(reg_gyro_sel),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .accel_sample_valid(accel_sample_valid),
  .accel_sample_ready(accel_sample_ready),
  .gyro_sample_valid(gyro_sample_valid),
  .accel_fifo_full_irq(accel_fifo_full_irq),
  .accel_fifo_wm_irq(accel_fifo_wm_irq), .gyro_fifo_irq(gyro_fifo_irq)
);

// ---- bench/imf_host_model.sv ----
// Purpose: host side of the byte-wide register port
// Assumes: one strobe per access, answer read one cycle later
// Notes:   write data is inverted once released
`timescale 1ns/100ps
module imf_host_model (
  input  wire       sys_clk,
  output reg        reg_gyro_sel,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg        reg_burst_end,
  input  wire [7:0] reg_rdata
);
  initial begin
    reg_gyro_sel  = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_burst_end = 1'b0;
  end
  task wr(input logic s, input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_gyro_sel <= s;
    reg_addr     <= a;
    reg_wdata    <= v;
    reg_wr       <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task rd(input logic s, input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_gyro_sel <= s;
    reg_addr     <= a;
    reg_rd       <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task bend;
    @(posedge sys_clk);
    reg_burst_end <= 1'b1;
    @(posedge sys_clk);
    reg_burst_end <= 1'b0;
  endtask
  task clr_fifo;
    wr(1'b0, 8'h7e, 8'hb0);
  endtask
endmodule // imf_host_model

// ---- bench/tb_top.sv ----
// Purpose: self-checking bench for imf_sample_fifo
// Assumes: host model drives the register port
// Notes:   row table first, then hand-written cases
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk, rst_n, reg_gyro_sel, reg_wr, reg_rd;
  logic        reg_burst_end, accel_sample_drop, accel_sample_valid;
  logic        accel_sample_ready, accel_range_change;
  logic        accel_filter_change, gyro_sample_valid, gyro_fifo_irq;
  logic        accel_irq_pin_a, accel_irq_pin_b, gyro_irq_pin_a;
  logic        gyro_irq_pin_b, accel_fifo_full_irq, accel_fifo_wm_irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [47:0] accel_sample, gyro_sample;
  logic [23:0] sensortime;
  logic [15:0] gyro_int_data;
  int          n_fail, checked;
  logic [31:0] rows [0:9] = '{32'h0_49_00_0_10, 32'h0_48_00_0_02,
    32'h0_45_00_0_80, 32'h0_24_00_0_00, 32'h1_0e_00_0_00,
    32'h0_30_00_0_00, 32'h0_48_03_1_03, 32'h1_34_20_1_20,
    32'h1_3d_05_1_05, 32'h1_3e_40_1_40};
  imf_sample_fifo uut (.*);
  imf_host_model host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task final_report;
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rc(input logic s, input logic [7:0] a, input logic [7:0] e);
    host.rd(s, a, d);
    chk(d, e);
  endtask
  task rq(input logic s, input logic [7:0] a, input logic [7:0] e[$]);
    foreach (e[i]) rc(s, a, e[i]);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task acc(input logic [47:0] s, input logic dr);
    int n;
    n = 0;
    @(posedge sys_clk);
    accel_sample       <= s;
    accel_sample_drop  <= dr;
    accel_sample_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (accel_sample_ready !== 1'b1 && n < 99);
    accel_sample_valid <= 1'b0;
    if (n == 99) begin
      n_fail++;
      final_report;
    end
  endtask
  task gyr(input logic [47:0] s);
    @(posedge sys_clk);
    gyro_sample       <= s;
    gyro_sample_valid <= 1'b1;
    @(posedge sys_clk);
    gyro_sample_valid <= 1'b0;
  endtask
  initial begin
    {rst_n, accel_sample_drop, accel_sample_valid} = 3'b000;
    {accel_range_change, accel_filter_change, gyro_sample_valid} = 3'b000;
    {accel_irq_pin_a, accel_irq_pin_b} = 2'b00;
    {gyro_irq_pin_a, gyro_irq_pin_b} = 2'b00;
    accel_sample  = 48'h0;
    gyro_sample   = 48'h0;
    sensortime    = 24'habcdef;
    gyro_int_data = 16'hbeef;
    n_fail  = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][8]) host.wr(rows[i][28], rows[i][27:20], rows[i][19:12]);
      rc(rows[i][28], rows[i][27:20], rows[i][7:0]);
    end
    // tagged frame, partial read repeat, time frame, overread
    host.wr(1'b0, 8'h53, 8'h10);
    host.wr(1'b0, 8'h49, 8'h54);
    accel_irq_pin_a <= 1'b1;
    acc(48'h112233445566, 1'b0);
    cyc(12);
    rc(1'b0, 8'h24, 8'h07);
    rq(1'b0, 8'h26, '{8'h85, 8'h11, 8'h22});
    host.bend;
    rq(1'b0, 8'h26, '{8'h85, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
    rq(1'b0, 8'h26, '{8'h44, 8'hef, 8'hcd, 8'hab, 8'h80, 8'h00});
    host.bend;
    // stop mode fill past capacity, lost frames reported
    accel_irq_pin_a <= 1'b0;
    for (int i = 0; i < 149; i++) acc(48'h0, 1'b0);
    cyc(30);
    chk({7'h0, accel_fifo_full_irq}, 8'h01);
    chk({7'h0, accel_fifo_wm_irq}, 8'h01);
    rc(1'b0, 8'h24, 8'hfe);
    rc(1'b0, 8'h25, 8'h03);
    rq(1'b0, 8'h26, '{8'h40, 8'h03, 8'h84});
    host.bend;
    host.clr_fifo;
    rc(1'b0, 8'h24, 8'h00);
    host.rd(1'b0, 8'h1e, d);
    cyc(3);
    chk({6'h0, accel_fifo_full_irq, accel_fifo_wm_irq}, 8'h00);
    rc(1'b0, 8'h26, 8'h80);
    host.bend;
    // drop frame, range change, halved input rate
    acc(48'h0, 1'b1);
    cyc(12);
    accel_range_change <= 1'b1;
    @(posedge sys_clk);
    accel_range_change <= 1'b0;
    host.wr(1'b0, 8'h45, 8'h90);
    for (int i = 0; i < 4; i++) acc(48'h0, 1'b0);
    cyc(30);
    rc(1'b0, 8'h24, 8'h14);
    rc(1'b0, 8'h26, 8'h50);
    host.rd(1'b0, 8'h26, d);
    rq(1'b0, 8'h26, '{8'h48, 8'h02, 8'h48, 8'h01, 8'h84});
    host.bend;
    // overwrite_mode mode overwrites oldest frames and counts them
    host.clr_fifo;
    host.wr(1'b0, 8'h48, 8'h00);
    host.wr(1'b0, 8'h45, 8'h80);
    for (int i = 0; i < 149; i++) acc(48'h0, 1'b0);
    cyc(30);
    rq(1'b0, 8'h26, '{8'h40, 8'h04, 8'h84});
    host.bend;
    // gyro tag on z lsb, partial frame dropped
    host.wr(1'b1, 8'h3e, 8'h40);
    gyro_irq_pin_a <= 1'b1;
    cyc(4);
    gyr(48'h5a42_3c3c_1234);
    gyro_irq_pin_a <= 1'b0;
    cyc(4);
    gyr(48'h5a42_3c3c_1234);
    gyr(48'h5a42_3c3c_5678);
    rc(1'b1, 8'h0e, 8'h03);
    rq(1'b1, 8'h3f, '{8'h34, 8'h12, 8'h3c, 8'h3c, 8'h43, 8'h5a, 8'hef, 8'hbe});
    rq(1'b1, 8'h3f, '{8'h34, 8'h12});
    host.bend;
    rq(1'b1, 8'h3f, '{8'h78, 8'h56, 8'h3c, 8'h3c, 8'h42});
    host.bend;
    rc(1'b1, 8'h0e, 8'h00);
    // gyro full in overwrite_mode then stop mode, overrun
    host.wr(1'b1, 8'h3d, 8'h00);
    for (int m = 0; m < 2; m++) begin
      host.wr(1'b1, 8'h3e, m ? 8'h40 : 8'h80);
      for (int i = 1; i < (m ? 100 : 99); i++) gyr(48'h0);
      cyc(2);
      chk({7'h0, gyro_fifo_irq}, 8'h00);
      gyr(48'h0);
      cyc(2);
      chk({7'h0, gyro_fifo_irq}, 8'h01);
    end
    gyr(48'h0);
    rc(1'b1, 8'h0e, 8'he4);
    host.rd(1'b1, 8'h0a, d);
    chk(d & 8'h10, 8'h10);
    host.wr(1'b1, 8'h3e, 8'h40);
    rc(1'b1, 8'h0e, 8'h00);
    // gyro watermark
    host.wr(1'b1, 8'h3d, 8'h03);
    gyr(48'h0);
    gyr(48'h0);
    cyc(2);
    chk({7'h0, gyro_fifo_irq}, 8'h00);
    gyr(48'h0);
    cyc(2);
    chk({7'h0, gyro_fifo_irq}, 8'h01);
    host.wr(1'b1, 8'h3d, 8'h03);
    rc(1'b1, 8'h0e, 8'h00);
    final_report;
  end
endmodule // tb_top
